// >>> hw/bmc_pkg.sv
// Purpose: constants, carriers and helpers for the binary motion command link
// Assumes: one 100 MHz clock, byte stream in and out, an outside executor
// Notes: the frame layout keeps serial byte positions for CAN too
// Behaviour
// [R1] device transmits only as the reply to a received command
// [R2] outside a reply the driver enable stays off, receive mode
// [R3] host sends no new command before it has the previous reply
// [R4] every accepted command gets exactly one reply frame
// [R5] command execution completes before the reply starts
// [R6] command core is op, type, motor/bank and a four-byte value
// [R7] serial frame: address, op, type, bank, value msb first, checksum
// [R8] command checksum is the 8-bit sum of all preceding bytes
// [R9] CAN frame carries only the seven core bytes
// [R10] serial reply: reply address, module address, status, op, value, checksum
// [R11] reply value bytes go out msb first
// [R12] reply checksum is the 8-bit sum of all other reply bytes
// [R13] CAN reply omits address and checksum bytes
// [R14] successful execution replies with status 100
// [R15] command stored into program memory replies with status 101
// [R16] error codes 1 to 6 as defined below
// [R17] stored commands can run standalone without a host
// [R18] checksum mismatch: no execution, reply wrong-checksum status
package bmc_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int PROG_DEPTH = 256;
    // byte positions within a frame
    localparam logic [3:0] POS_ADDR = 4'h0;
    localparam logic [3:0] POS_OP = 4'h1;
    localparam logic [3:0] POS_TYPE = 4'h2;
    localparam logic [3:0] POS_BANK = 4'h3;
    localparam logic [3:0] POS_VAL = 4'h4;
    localparam logic [3:0] POS_CKSUM = 4'h8;
    localparam logic [3:0] POS_CAN_LAST = 4'h7;
    // status codes (see [R14]) (see [R15]) (see [R16])
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_STORED = 8'h65;
    localparam logic [7:0] ST_BAD_CKSUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_CFG_LOCKED = 8'h05;
    localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
    localparam logic [7:0] ERR_NONE = 8'h00;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] value;
    } bmc_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] op;
        logic [31:0] value;
    } bmc_reply_t;

    typedef struct packed {
        logic [7:0] err;
        logic [31:0] value;
    } bmc_result_t;

    // wrap-around byte addition, shared by the receive and send checksums
    function automatic logic [7:0] bmc_add8(input logic [7:0] a, input logic [7:0] b);
        bmc_add8 = a + b;
    endfunction : bmc_add8
endpackage : bmc_pkg

// >>> hw/bmc_fifo.sv
// Purpose: byte fifo between the receive stream and the frame parser
// Assumes: single clock, push and pop may happen in the same cycle
// Notes: flags are registered so they can drive ports directly
`timescale 1ns/1ps
module bmc_fifo #(
    parameter int WIDTH = bmc_pkg::BYTE_W,
    parameter int DEPTH = bmc_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, ready_d, valid_q, valid_d;
    logic push, pop;

    always_comb begin
        push = in_valid && ready_q;
        pop = out_ready && valid_q;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ready_d = (cnt_d != (AW+1)'(DEPTH));
        valid_d = (cnt_d != '0);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
        end
    end

    // storage has no reset; contents are only read behind valid_q
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // flags kept in true polarity so the ports come straight from flops
    assign in_ready = ready_q;
    assign out_valid = valid_q;
    assign out_data = mem_q[rp_q];
endmodule : bmc_fifo

// >>> hw/bmc_prog_mem.sv
// Purpose: program store for commands downloaded for standalone running
// Assumes: one write port, one read port, read data registered
// Notes: stands in for the nonvolatile store; contents are not reset
`timescale 1ns/1ps
module bmc_prog_mem #(
    parameter int DEPTH = bmc_pkg::PROG_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire bmc_pkg::bmc_cmd_t wr_data,
    input wire logic [AW-1:0] rd_addr,
    output bmc_pkg::bmc_cmd_t rd_data
);
    bmc_pkg::bmc_cmd_t mem_q [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule : bmc_prog_mem

// >>> hw/bmc_link.sv
// Purpose: frame receive, check, execute handoff and reply for the command link
// Assumes: byte streams are synchronous to core_clk; an outside executor runs commands
// Notes: frames for another module address are dropped silently on serial links
`timescale 1ns/1ps
module bmc_link #(
    parameter int FIFO_DEPTH = bmc_pkg::FIFO_DEPTH,
    parameter int PROG_DEPTH = bmc_pkg::PROG_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic can_mode,
    input wire logic [7:0] module_addr,
    input wire logic [7:0] reply_addr,
    input wire logic prog_load,
    input wire logic run_en,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic tx_en,
    output logic exec_req,
    output bmc_pkg::bmc_cmd_t exec_cmd,
    output logic exec_from_prog,
    input wire logic exec_done,
    input wire bmc_pkg::bmc_result_t exec_result
);
    localparam int PAW = $clog2(PROG_DEPTH);

    typedef enum logic [3:0] {
        S_IDLE, S_RX, S_CHECK, S_EXEC, S_REPLY, S_FETCH, S_RUN_EXEC
    } bmc_state_t;

    bmc_state_t state_q, state_d;
    logic [8:0][7:0] frm_q, frm_d;
    logic [3:0] pos_q, pos_d, tx_idx_q, tx_idx_d;
    logic [7:0] sum_q, sum_d, tx_sum_q, tx_sum_d, tx_data_q, tx_data_d;
    logic tx_valid_q, tx_valid_d, tx_en_q, tx_en_d;
    logic exec_req_q, exec_req_d, from_prog_q, from_prog_d;
    bmc_pkg::bmc_cmd_t exec_cmd_q, exec_cmd_d, frm_cmd, prog_rd;
    bmc_pkg::bmc_reply_t rep_q, rep_d;
    logic [PAW-1:0] wr_ptr_q, wr_ptr_d, pc_q, pc_d;
    logic prog_has_q, prog_has_d;
    logic fifo_valid, fifo_pop, mem_wr, go_reply;
    logic [7:0] fifo_data, tx_sum_n;
    logic [3:0] last_pos;
    logic ck_ok, addr_ok;

    bmc_fifo #(.WIDTH(bmc_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    bmc_prog_mem #(.DEPTH(PROG_DEPTH), .AW(PAW)) u_prog_mem (
        .core_clk(core_clk),
        .wr_en(mem_wr),
        .wr_addr(wr_ptr_q),
        .wr_data(frm_cmd),
        .rd_addr(pc_q),
        .rd_data(prog_rd)
    );

    // reply byte at a given frame position; position 8 is handled by the running sum
    function automatic logic [7:0] reply_byte(input logic [3:0] idx, input bmc_pkg::bmc_reply_t r,
                                              input logic [7:0] maddr, input logic [7:0] raddr);
        unique case (idx)
            4'h0: reply_byte = raddr;
            4'h1: reply_byte = maddr;
            4'h2: reply_byte = r.status;
            4'h3: reply_byte = r.op;
            4'h4: reply_byte = r.value[31:24];
            4'h5: reply_byte = r.value[23:16];
            4'h6: reply_byte = r.value[15:8];
            default: reply_byte = r.value[7:0];
        endcase
    endfunction : reply_byte

    always_comb begin
        last_pos = can_mode ? bmc_pkg::POS_CAN_LAST : bmc_pkg::POS_CKSUM; // see [R7] see [R9]
        frm_cmd = '{op: frm_q[bmc_pkg::POS_OP], typ: frm_q[bmc_pkg::POS_TYPE],
                    bank: frm_q[bmc_pkg::POS_BANK], value: {frm_q[4], frm_q[5], frm_q[6], frm_q[7]}}; // see [R6]
        ck_ok = can_mode || (frm_q[bmc_pkg::POS_CKSUM] == sum_q); // see [R18]
        addr_ok = can_mode || (frm_q[bmc_pkg::POS_ADDR] == module_addr);
        tx_sum_n = bmc_pkg::bmc_add8(tx_sum_q, tx_data_q);
        state_d = state_q;
        frm_d = frm_q;
        pos_d = pos_q;
        sum_d = sum_q;
        tx_idx_d = tx_idx_q;
        tx_sum_d = tx_sum_q;
        tx_data_d = tx_data_q;
        tx_valid_d = tx_valid_q;
        tx_en_d = tx_en_q;
        exec_req_d = 1'b0;
        exec_cmd_d = exec_cmd_q;
        from_prog_d = from_prog_q;
        rep_d = rep_q;
        wr_ptr_d = wr_ptr_q;
        prog_has_d = prog_has_q;
        pc_d = pc_q;
        fifo_pop = 1'b0;
        mem_wr = 1'b0;
        go_reply = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                // a pending host frame takes precedence over standalone running
                if (fifo_valid) begin
                    state_d = S_RX;
                    pos_d = can_mode ? bmc_pkg::POS_OP : bmc_pkg::POS_ADDR;
                    sum_d = '0;
                end else if (run_en && prog_has_q) begin
                    state_d = S_FETCH; // see [R17]
                end
            end
            S_RX: begin
                fifo_pop = 1'b1;
                if (fifo_valid) begin
                    frm_d[pos_q] = fifo_data;
                    if (pos_q != bmc_pkg::POS_CKSUM) begin
                        sum_d = bmc_pkg::bmc_add8(sum_q, fifo_data); // see [R8]
                    end
                    if (pos_q == last_pos) begin
                        state_d = S_CHECK;
                    end else begin
                        pos_d = pos_q + 4'h1;
                    end
                end
            end
            S_CHECK: begin
                if (!addr_ok) begin
                    state_d = S_IDLE;
                end else if (!ck_ok) begin
                    rep_d = '{status: bmc_pkg::ST_BAD_CKSUM, op: frm_cmd.op, value: '0}; // see [R18] see [R16]
                    go_reply = 1'b1;
                end else if (prog_load) begin
                    mem_wr = 1'b1;
                    wr_ptr_d = wr_ptr_q + 1'b1;
                    prog_has_d = 1'b1;
                    rep_d = '{status: bmc_pkg::ST_STORED, op: frm_cmd.op, value: 32'(wr_ptr_q)}; // see [R15]
                    go_reply = 1'b1;
                end else begin
                    exec_req_d = 1'b1;
                    exec_cmd_d = frm_cmd;
                    from_prog_d = 1'b0;
                    state_d = S_EXEC;
                end
            end
            S_EXEC: begin
                // the reply waits for the executor, so outputs and inputs are settled first
                if (exec_done) begin
                    rep_d.status = (exec_result.err == bmc_pkg::ERR_NONE) ? bmc_pkg::ST_OK
                                                                          : exec_result.err; // see [R14] see [R16]
                    rep_d.op = exec_cmd_q.op;
                    rep_d.value = exec_result.value;
                    go_reply = 1'b1; // see [R5]
                end
            end
            S_REPLY: begin
                if (tx_valid_q && tx_ready) begin
                    tx_sum_d = tx_sum_n; // see [R12]
                    if (tx_idx_q == last_pos) begin
                        tx_valid_d = 1'b0;
                        tx_en_d = 1'b0; // see [R2] see [R4]
                        state_d = S_IDLE;
                    end else begin
                        tx_idx_d = tx_idx_q + 4'h1;
                        tx_data_d = (tx_idx_q + 4'h1 == bmc_pkg::POS_CKSUM) ? tx_sum_n
                                    : reply_byte(tx_idx_q + 4'h1, rep_q, module_addr, reply_addr); // see [R10] see [R11]
                    end
                end
            end
            S_FETCH: begin
                exec_req_d = 1'b1;
                exec_cmd_d = prog_rd;
                from_prog_d = 1'b1;
                state_d = S_RUN_EXEC;
            end
            S_RUN_EXEC: begin
                // standalone commands are never answered on the link
                if (exec_done) begin
                    pc_d = (pc_q + 1'b1 == wr_ptr_q) ? '0 : pc_q + 1'b1; // see [R17]
                    state_d = S_IDLE;
                end
            end
        endcase
        if (go_reply) begin
            // the only place the driver is switched on: after a received command
            state_d = S_REPLY; // see [R1]
            tx_en_d = 1'b1;
            tx_valid_d = 1'b1;
            tx_idx_d = can_mode ? bmc_pkg::POS_OP : bmc_pkg::POS_ADDR; // see [R13]
            tx_data_d = reply_byte(tx_idx_d, rep_d, module_addr, reply_addr);
            tx_sum_d = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            frm_q <= '0;
            pos_q <= '0;
            sum_q <= '0;
            tx_idx_q <= '0;
            tx_sum_q <= '0;
            tx_data_q <= '0;
            tx_valid_q <= 1'b0;
            tx_en_q <= 1'b0;
            exec_req_q <= 1'b0;
            exec_cmd_q <= '0;
            from_prog_q <= 1'b0;
            rep_q <= '0;
            wr_ptr_q <= '0;
            prog_has_q <= 1'b0;
            pc_q <= '0;
        end else begin
            state_q <= state_d;
            frm_q <= frm_d;
            pos_q <= pos_d;
            sum_q <= sum_d;
            tx_idx_q <= tx_idx_d;
            tx_sum_q <= tx_sum_d;
            tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            tx_en_q <= tx_en_d;
            exec_req_q <= exec_req_d;
            exec_cmd_q <= exec_cmd_d;
            from_prog_q <= from_prog_d;
            rep_q <= rep_d;
            wr_ptr_q <= wr_ptr_d;
            prog_has_q <= prog_has_d;
            pc_q <= pc_d;
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign tx_en = tx_en_q;
    assign exec_req = exec_req_q;
    assign exec_cmd = exec_cmd_q;
    assign exec_from_prog = from_prog_q;

    sequence s_last_sent;
        tx_valid_q && tx_ready && (tx_idx_q == last_pos);
    endsequence

    sequence s_bad_frame;
        state_q == S_CHECK && addr_ok && !ck_ok;
    endsequence

    a_tx_only_reply: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R1]
        tx_valid_q |-> (state_q == S_REPLY) && tx_en_q)
        else $error("transmit outside a reply");

    a_idle_receive: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R2]
        (state_q != S_REPLY) |-> !tx_en_q)
        else $error("driver enabled outside a reply");

    a_reply_ends_once: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R4]
        s_last_sent |=> !tx_en_q && !tx_valid_q && (state_q == S_IDLE))
        else $error("reply did not end after its last byte");

    a_exec_then_reply: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R5]
        (state_q == S_EXEC && !exec_done) |=> !tx_en_q)
        else $error("reply started before execution finished");

    a_ok_status: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R14]
        (state_q == S_EXEC && exec_done && exec_result.err == bmc_pkg::ERR_NONE)
        |=> rep_q.status == bmc_pkg::ST_OK && tx_valid_q)
        else $error("success status not 100");

    a_stored_status: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R15]
        (state_q == S_CHECK && addr_ok && ck_ok && prog_load)
        |=> rep_q.status == bmc_pkg::ST_STORED && !exec_req_q && wr_ptr_q == $past(wr_ptr_q) + 1'b1)
        else $error("stored command status or pointer wrong");

    a_bad_cksum: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R18]
        s_bad_frame |=> (rep_q.status == bmc_pkg::ST_BAD_CKSUM && !exec_req_q)[*2])
        else $error("checksum error executed or misreported");

    a_value_msb: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R11]
        (tx_valid_q && tx_idx_q == bmc_pkg::POS_VAL) |-> tx_data_q == rep_q.value[31:24])
        else $error("reply value not msb first");

    a_reply_cksum: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R12]
        (tx_valid_q && tx_idx_q == bmc_pkg::POS_CKSUM)
        |-> tx_data_q == bmc_pkg::bmc_add8(bmc_pkg::bmc_add8(reply_addr, module_addr),
            bmc_pkg::bmc_add8(bmc_pkg::bmc_add8(rep_q.status, rep_q.op),
            bmc_pkg::bmc_add8(bmc_pkg::bmc_add8(rep_q.value[31:24], rep_q.value[23:16]),
            bmc_pkg::bmc_add8(rep_q.value[15:8], rep_q.value[7:0])))))
        else $error("reply checksum wrong");

    a_can_no_frame: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R13]
        (can_mode && tx_valid_q) |-> tx_idx_q >= bmc_pkg::POS_OP && tx_idx_q <= bmc_pkg::POS_CAN_LAST)
        else $error("CAN reply carries address or checksum");

    a_run_silent: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R17]
        (state_q == S_FETCH) |=> exec_req_q && from_prog_q ##1 !tx_en_q)
        else $error("standalone step misbehaved");
endmodule : bmc_link

// >>> test/bmc_host_model.sv
// Purpose: far side of the link: executor answering requests, transmitter taking reply bytes
// Assumes: drives its outputs 1 ns after the rising edge, like the bench
// Notes: result lines show a changing pattern outside the done pulse so stale values are never read
`timescale 1ns/1ps
module bmc_host_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic exec_req,
    input wire bmc_pkg::bmc_cmd_t exec_cmd,
    input wire logic exec_from_prog,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_en,
    output logic exec_done,
    output bmc_pkg::bmc_result_t exec_result,
    output logic tx_ready
);
    int lat = 3;
    int cnt = 0;
    int req_cnt = 0;
    int viol = 0;
    bit stall = 0;
    logic [7:0] err = 8'h00;
    logic [31:0] val = 32'h0000_0000;
    logic [7:0] rxq[$];
    bmc_pkg::bmc_cmd_t last_cmd;
    logic last_prog;
    logic pulse;
    initial begin
        exec_done = 1'b0;
        exec_result = '0;
        tx_ready = 1'b1;
    end
    always @(posedge core_clk or negedge rst_n) begin
        pulse = 1'b0;
        if (!rst_n) begin
            cnt = 0;
        end else begin
            if (cnt > 0) begin
                cnt--;
                pulse = (cnt == 0);
            end
            // one outstanding request, one done pulse at least a cycle later
            if (exec_req === 1'b1) begin
                req_cnt++;
                last_cmd = exec_cmd;
                last_prog = exec_from_prog;
                cnt = lat;
            end
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                rxq.push_back(tx_data);
            end
            if (tx_en !== tx_valid) begin
                viol++;
            end
            if (cnt > 0 && tx_en === 1'b1) begin
                viol++;
            end
        end
        exec_done <= #1 pulse;
        exec_result <= #1 pulse ? {err, val} : ~{exec_result};
        // a stalling transmitter accepts every other cycle
        tx_ready <= #1 stall ? ~tx_ready : 1'b1;
    end
endmodule : bmc_host_model

// >>> test/binary_motion_command_link_tb.sv
// Purpose: self-checking bench for the command link: framing, status, program store, fifo
// Assumes: inputs change 1 ns after the rising edge; replies are collected by the host model
// Notes: the fifo test breaks the one-command-at-a-time habit on purpose to fill the buffer
`timescale 1ns/1ps
module binary_motion_command_link_tb;
    localparam logic [7:0] MA = 8'h2a;
    localparam logic [7:0] RA = 8'h02;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic can_mode = 1'b0;
    logic prog_load = 1'b0;
    logic run_en = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_ready, tx_valid, tx_ready, tx_en, exec_req, exec_from_prog, exec_done;
    logic [7:0] tx_data;
    bmc_pkg::bmc_cmd_t exec_cmd;
    bmc_pkg::bmc_result_t exec_result;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] fq[$];

    bmc_link DUT (.core_clk(core_clk), .rst_n(rst_n), .can_mode(can_mode), .module_addr(MA),
        .reply_addr(RA), .prog_load(prog_load), .run_en(run_en), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_en(tx_en), .exec_req(exec_req), .exec_cmd(exec_cmd),
        .exec_from_prog(exec_from_prog), .exec_done(exec_done), .exec_result(exec_result));
    bmc_host_model m (.core_clk(core_clk), .rst_n(rst_n), .exec_req(exec_req), .exec_cmd(exec_cmd),
        .exec_from_prog(exec_from_prog), .tx_valid(tx_valid), .tx_data(tx_data), .tx_en(tx_en),
        .exec_done(exec_done), .exec_result(exec_result), .tx_ready(tx_ready));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge core_clk) begin
        cyc++;
        // the tests need about 1500 cycles
        if (cyc > 20000) begin
            mismatches++;
            $display("ERROR at %0t: run did not finish", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [55:0] g, input logic [55:0] e, input string msg);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR at %0t: %s got %h exp %h", $time, msg, g, e);
        end
    endtask : chk

    // builds a frame with type 3 and bank 1; bad adds one to the checksum
    task automatic build(input logic [7:0] ad, input logic [7:0] op, input logic [31:0] v, input bit bad);
        logic [7:0] s;
        fq = {};
        if (!can_mode) fq.push_back(ad);
        fq.push_back(op);
        fq.push_back(8'h03);
        fq.push_back(8'h01);
        for (int i = 3; i >= 0; i--) fq.push_back(v[i*8 +: 8]);
        if (!can_mode) begin
            s = 8'h00;
            foreach (fq[i]) s = s + fq[i];
            fq.push_back(bad ? s + 8'h01 : s);
        end
    endtask : build

    task automatic push(input logic [7:0] b);
        rx_valid = 1'b1;
        rx_data = b;
        for (int n = 0; n < 1000 && rx_ready !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
    endtask : push

    task automatic send;
        foreach (fq[i]) push(fq[i]);
        rx_valid = 1'b0;
    endtask : send

    task automatic reply(input logic [7:0] st, input logic [7:0] op, input logic [31:0] v);
        logic [7:0] e[$];
        logic [7:0] s;
        logic [7:0] g;
        if (!can_mode) e.push_back(RA);
        e.push_back(MA);
        e.push_back(st);
        e.push_back(op);
        for (int i = 3; i >= 0; i--) e.push_back(v[i*8 +: 8]);
        if (!can_mode) begin
            s = 8'h00;
            foreach (e[i]) s = s + e[i];
            e.push_back(s);
        end
        for (int n = 0; n < 3000 && m.rxq.size() < e.size(); n++) begin
            @(posedge core_clk);
            #1;
        end
        foreach (e[i]) begin
            g = (m.rxq.size() > 0) ? m.rxq.pop_front() : 8'hxx;
            chk({48'h0, g}, {48'h0, e[i]}, "reply byte");
        end
    endtask : reply

    task automatic do_cmd(input logic [7:0] op, input logic [31:0] v, input logic [7:0] st,
                          input logic [31:0] rv, input bit ex, input bit bad);
        int c0;
        c0 = m.req_cnt;
        build(MA, op, v, bad);
        send();
        reply(st, op, rv);
        chk(56'(m.req_cnt - c0), 56'(ex), "exec count");
        if (ex) begin
            chk(m.last_cmd, {op, 8'h03, 8'h01, v}, "exec cmd");
            chk({55'h0, m.last_prog}, 56'h0, "host command flagged as program");
        end
    endtask : do_cmd

    task automatic t_ok;
        m.val = 32'hfe01_9a37;
        do_cmd(8'h05, 32'h80ff_7f10, bmc_pkg::ST_OK, 32'hfe01_9a37, 1, 0);
        $display("test ok done");
    endtask : t_ok

    task automatic t_err;
        for (int e = 2; e <= 6; e++) begin
            m.err = 8'(e);
            do_cmd(8'h0a, 32'(e), 8'(e), m.val, 1, 0);
        end
        m.err = 8'h00;
        do_cmd(8'h06, 32'h0000_0001, bmc_pkg::ST_BAD_CKSUM, 32'h0, 0, 1);
        $display("test errors done");
    endtask : t_err

    task automatic t_store;
        int c;
        prog_load = 1'b1;
        do_cmd(8'h04, 32'h0000_0200, bmc_pkg::ST_STORED, 32'h0, 0, 0);
        do_cmd(8'h03, 32'h0000_0007, bmc_pkg::ST_STORED, 32'h1, 0, 0);
        prog_load = 1'b0;
        c = m.req_cnt;
        run_en = 1'b1;
        for (int n = 0; n < 200 && m.req_cnt == c; n++) begin
            @(posedge core_clk);
            #1;
        end
        run_en = 1'b0;
        chk({55'h0, m.last_prog}, 56'h1, "program step flag");
        chk(m.last_cmd, {8'h04, 8'h03, 8'h01, 32'h0000_0200}, "program step cmd");
        repeat (40) @(posedge core_clk);
        #1;
        chk(56'(m.rxq.size()), 56'h0, "reply without command");
        $display("test store done");
    endtask : t_store

    task automatic t_can;
        can_mode = 1'b1;
        do_cmd(8'h01, 32'h0102_0304, bmc_pkg::ST_OK, m.val, 1, 0);
        can_mode = 1'b0;
        $display("test can done");
    endtask : t_can

    task automatic t_addr;
        int c0;
        c0 = m.req_cnt;
        build(MA + 8'h01, 8'h05, 32'h0000_0010, 0);
        send();
        repeat (60) @(posedge core_clk);
        #1;
        chk(56'(m.req_cnt - c0), 56'h0, "foreign frame executed");
        chk(56'(m.rxq.size()), 56'h0, "foreign frame answered");
        $display("test address done");
    endtask : t_addr

    // slow executor and stalling transmitter while two more frames arrive
    task automatic t_fifo;
        logic [7:0] more[$];
        m.lat = 300;
        m.stall = 1;
        build(MA, 8'h05, 32'h0000_0001, 0);
        more = fq;
        build(MA, 8'h06, 32'h0000_0002, 0);
        more = {more, fq};
        build(MA, 8'h07, 32'h0000_0003, 0);
        more = {more, fq};
        // one unbroken stream: the parser takes nine bytes, then sixteen fill the buffer
        for (int i = 0; i < 25; i++) push(more[i]);
        chk({55'h0, rx_ready}, 56'h0, "fifo full not refused");
        push(more[25]);
        push(more[26]);
        rx_valid = 1'b0;
        reply(bmc_pkg::ST_OK, 8'h05, m.val);
        reply(bmc_pkg::ST_OK, 8'h06, m.val);
        reply(bmc_pkg::ST_OK, 8'h07, m.val);
        m.lat = 3;
        m.stall = 0;
        $display("test fifo done");
    endtask : t_fifo

    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_ok();
        t_err();
        t_store();
        t_can();
        t_addr();
        t_fifo();
        chk(56'(m.viol), 56'h0, "transmit outside reply");
        end_sim();
    end
endmodule : binary_motion_command_link_tb
